// ===== design/occ_clock_control.sv
`timescale 1ns/1ps
module occ_clock_control
  import occ_pkg::*;
(
  input  wire logic        clock,            // 100 MHz system clock
  input  wire logic        rst,              // External reset, async high
  input  wire logic        main_osc_tick,    // Main oscillator edge enable
  input  wire logic        rosc_tick,        // Internal oscillator enable
  input  wire logic        cpumode_wr,       // Mode register write strobe
  input  wire logic [7:0]  cpumode_wdata,    // Mode register write data
  input  wire logic        rosc_div_wr,      // Divider select write
  input  wire logic [1:0]  rosc_div_wdata,   // Divider select data
  input  wire logic        misc_wr,          // Misc register write
  input  wire logic [7:0]  misc_wdata,       // Misc register data
  input  wire logic        t1_wr,            // Software timer load
  input  wire logic [7:0]  t1_wdata,         // Timer load value
  input  wire logic [7:0]  pre_wdata,        // Prescaler load value
  input  wire logic        stop_instruction, // Stop executed, pulse
  input  wire logic        stop_allowed,     // Watchdog stop function on
  input  wire logic        wake_event,       // Stop release request
  input  wire logic        osc_stop_det,     // Main oscillation lost
  input  wire logic        flash_busy,       // Program or erase running
  input  wire logic        wdt_running,      // Watchdog active
  input  wire logic        boot_select_pin,  // Boot strap
  output logic [7:0]       cpumode_rdata,    // Mode register readback
  output logic [7:0]       misc_rdata,       // Misc register readback
  output logic [1:0]       rosc_div,         // Internal divider select
  output logic             main_osc_enable,  // Main oscillator run
  output logic             rosc_enable,      // Internal oscillator run
  output logic             cpu_clk_en,       // Processor clock enable
  output logic             wdt_count_en,     // Watchdog count source
  output logic             stop_active,      // Stopped or stabilizing
  output logic             osc_stop_reset,   // Internal reset pulse
  output logic             wdt_reinit,       // Watchdog clear
  output logic             boot_mode,        // Boot mode selected
  output logic [15:0]      reset_vector      // Start address location
);
  occ_state_t  state;
  occ_state_t  next_state;
  logic [7:0]  cpumode;
  logic [7:0]  next_cpumode;
  logic        once_done;
  logic        next_once_done;
  logic [7:0]  misc;
  logic [7:0]  next_misc;
  logic [1:0]  next_rosc_div;
  logic [3:0]  div_cnt;
  logic [3:0]  next_div_cnt;
  logic        strap_taken;
  logic        stab_load;
  logic [7:0]  stab_t1;
  logic [7:0]  stab_pre;
  logic        stab_done;
  logic        sel_rosc;
  logic        src_tick;
  logic        stop_go;

  // Source ticks per processor clock; five bits so divide-by-16 fits
  function automatic logic [4:0] div_ratio(input logic [1:0] sel,
                                           input logic [1:0] rdiv);
    logic [4:0] r;
    r = 5'h01;
    unique case (sel)
      CLKDIV_MAIN_D8: r = 5'h08;
      CLKDIV_MAIN_D2: r = 5'h02;
      CLKDIV_MAIN_D1: r = 5'h01;
      CLKDIV_ROSC:    r = 5'h02 << rdiv;
    endcase
    return r;
  endfunction : div_ratio

  assign sel_rosc = cpumode[CM_DIV_HI:CM_DIV_LO] == CLKDIV_ROSC;
  assign src_tick = sel_rosc ? rosc_tick : main_osc_tick;
  assign stop_go  = stop_instruction && stop_allowed && state == OCC_RUN;

  // Stabilization wait timer; stop entry may overwrite software values
  always_comb begin
    stab_load = t1_wr;
    stab_t1   = t1_wdata;
    stab_pre  = pre_wdata;
    if (stop_go && !misc[MC_AUTO_STAB]) begin
      stab_load = 1'b1;
      stab_t1   = AUTO_T1;
      stab_pre  = AUTO_PRE;
    end
  end

  occ_stab_timer #(.W(8)) u_stab (
    .clock     (clock),
    .rst       (rst),
    .load      (stab_load),
    .load_t1   (stab_t1),
    .load_pre  (stab_pre),
    .tick      (state == OCC_STABILIZE && src_tick),
    .underflow (stab_done)
  );

  // Register file; the osc-stop reset reinitializes all but two bits
  always_comb begin
    next_cpumode   = cpumode;
    next_once_done = once_done;
    next_misc      = misc;
    next_rosc_div  = rosc_div;
    if (osc_stop_reset) begin
      next_cpumode   = CPUMODE_RST;
      next_once_done = 1'b0;
      next_rosc_div  = ROSC_DIV_RST;
      next_misc      = MISC_RST;
      next_misc[MC_DET_EN]   = misc[MC_DET_EN];
      next_misc[MC_DET_STAT] = misc[MC_DET_STAT];
    end else begin
      if (cpumode_wr) begin
        // Locked bits keep value once written, guarding against run-away
        next_cpumode = once_done
          ? (cpumode_wdata & ~CM_ONCE_MASK) | (cpumode & CM_ONCE_MASK)
          : cpumode_wdata;
        next_once_done = 1'b1;
        // Refuse to stop the oscillator that the write selects; main only if it already clocks the core
        if (!sel_rosc && cpumode_wdata[CM_DIV_HI:CM_DIV_LO] != CLKDIV_ROSC)
          next_cpumode[CM_MAIN_STOP] = 1'b0;
        if (cpumode_wdata[CM_DIV_HI:CM_DIV_LO] == CLKDIV_ROSC)
          next_cpumode[CM_ROSC_STOP] = 1'b0;
        if (!sel_rosc &&
            cpumode_wdata[CM_DIV_HI:CM_DIV_LO] == CLKDIV_ROSC)
          next_rosc_div = ROSC_DIV_MID;
      end
      if (rosc_div_wr && !(cpumode_wr && !sel_rosc &&
          cpumode_wdata[CM_DIV_HI:CM_DIV_LO] == CLKDIV_ROSC))
        next_rosc_div = rosc_div_wdata;
      if (misc_wr) begin
        next_misc[MC_AUTO_STAB] = misc_wdata[MC_AUTO_STAB];
        next_misc[MC_DET_EN]    = misc_wdata[MC_DET_EN];
        if (!misc_wdata[MC_DET_EN])
          next_misc[MC_DET_STAT] = 1'b0;
      end
      // A loss event in the clearing cycle still sets the status
      if (osc_stop_det && misc[MC_DET_EN])
        next_misc[MC_DET_STAT] = 1'b1;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cpumode   <= CPUMODE_RST;
      once_done <= 1'b0;
      misc      <= MISC_RST;
      rosc_div  <= ROSC_DIV_RST;
    end else begin
      cpumode   <= next_cpumode;
      once_done <= next_once_done;
      misc      <= next_misc;
      rosc_div  <= next_rosc_div;
    end
  end

  // Stop sequencing and processor clock divider
  always_comb begin
    next_state   = state;
    next_div_cnt = div_cnt;
    unique case (state)
      OCC_RUN:       if (stop_go) next_state = OCC_STOPPED;
      OCC_STOPPED:   if (wake_event) next_state = OCC_STABILIZE;
      OCC_STABILIZE: if (stab_done) next_state = OCC_RUN;
    endcase
    if (osc_stop_reset)
      next_state = OCC_RUN;
    if (state != OCC_RUN)
      next_div_cnt = '0;
    else if (src_tick)
      next_div_cnt = ({1'b0, div_cnt} + 5'h01 >= div_ratio(
        cpumode[CM_DIV_HI:CM_DIV_LO], rosc_div)) ? 4'h0 : div_cnt + 4'h1;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state           <= OCC_RUN;
      div_cnt         <= '0;
      cpu_clk_en      <= 1'b0;
      wdt_count_en    <= 1'b0;
      main_osc_enable <= 1'b0;
      rosc_enable     <= 1'b0;
      stop_active     <= 1'b0;
      osc_stop_reset  <= 1'b0;
      wdt_reinit      <= 1'b0;
      cpumode_rdata   <= CPUMODE_RST;
      misc_rdata      <= MISC_RST;
    end else begin
      state           <= next_state;
      div_cnt         <= next_div_cnt;
      cpu_clk_en      <= state == OCC_RUN && src_tick &&
                         next_div_cnt == 4'h0;
      wdt_count_en    <= state != OCC_STOPPED && src_tick;
      main_osc_enable <= next_state != OCC_STOPPED &&
                         !next_cpumode[CM_MAIN_STOP];
      rosc_enable     <= next_state != OCC_STOPPED &&
                         !next_cpumode[CM_ROSC_STOP];
      stop_active     <= next_state != OCC_RUN;
      osc_stop_reset  <= osc_stop_det && misc[MC_DET_EN] &&
                         !osc_stop_reset;
      wdt_reinit      <= flash_busy && wdt_running;
      cpumode_rdata   <= next_cpumode;
      misc_rdata      <= next_misc;
    end
  end

  // Boot strap caught on the first edge after reset release
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      strap_taken  <= 1'b0;
      boot_mode    <= 1'b0;
      reset_vector <= USER_VECTOR;
    end else if (!strap_taken) begin
      strap_taken  <= 1'b1;
      boot_mode    <= boot_select_pin;
      reset_vector <= boot_select_pin ? BOOT_VECTOR : USER_VECTOR;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  auto_stab_load_a: assert property (
    stop_go && !misc[MC_AUTO_STAB] |-> stab_t1 == AUTO_T1 &&
      stab_pre == AUTO_PRE && stab_load)
    else $error("auto stabilization load missing");
  rosc_mid_div_a: assert property (
    cpumode_wr && !sel_rosc && !osc_stop_reset &&
    cpumode_wdata[CM_DIV_HI:CM_DIV_LO] == CLKDIV_ROSC
    |=> rosc_div == ROSC_DIV_MID)
    else $error("divider not middle speed");
  wdt_source_a: assert property (
    state == OCC_RUN && sel_rosc && rosc_tick && !$past(rst)
    |=> wdt_count_en)
    else $error("watchdog source wrong");
  det_retain_a: assert property (
    osc_stop_reset |=> misc[MC_DET_EN] == $past(misc[MC_DET_EN]) &&
      misc[MC_DET_STAT] == $past(misc[MC_DET_STAT]))
    else $error("detect bits lost on osc reset");
  stat_clear_a: assert property (
    $fell(misc[MC_DET_STAT]) |-> $past(misc_wr) &&
      !$past(misc_wdata[MC_DET_EN]))
    else $error("status cleared wrongly");
  wdt_reinit_a: assert property (
    flash_busy && wdt_running |=> wdt_reinit)
    else $error("watchdog not reinitialized");
  once_lock_a: assert property (
    once_done && cpumode_wr && !osc_stop_reset
    |=> (cpumode & CM_ONCE_MASK) == $past(cpumode & CM_ONCE_MASK))
    else $error("locked mode bits changed");
  gated_a: assert property (
    state == OCC_STABILIZE && !stab_done |=> !cpu_clk_en)
    else $error("clock ran during stabilization");
  stop_gate_a: assert property (
    stop_go && !osc_stop_reset |=> state == OCC_STOPPED &&
      !main_osc_enable && !rosc_enable)
    else $error("stop did not halt oscillators");

  stop_cycle_c: cover property (
    state == OCC_STABILIZE ##[1:600] state == OCC_RUN);
  osc_reset_c:  cover property (osc_stop_reset);
  rosc_sel_c:   cover property (sel_rosc && cpu_clk_en);
  boot_c:       cover property (boot_mode);
endmodule : occ_clock_control

// ===== design/occ_pkg.sv
package occ_pkg;
  // Processor mode register fields
  localparam int           CM_DIV_HI      = 7;
  localparam int           CM_DIV_LO      = 6;
  localparam int           CM_OSC_MODE    = 5;
  localparam int           CM_MAIN_STOP   = 4;
  localparam int           CM_ROSC_STOP   = 3;
  localparam int           CM_OPMODE_HI   = 1;
  localparam int           CM_OPMODE_LO   = 0;
  localparam logic [7:0]   CPUMODE_RST    = 8'h00;
  // Bits that accept one write after reset: oscillation mode and op mode
  localparam logic [7:0]   CM_ONCE_MASK   = 8'h23;
  // Misc control register fields
  localparam int           MC_AUTO_STAB   = 0;
  localparam int           MC_DET_EN      = 1;
  localparam int           MC_DET_STAT    = 3;
  localparam logic [7:0]   MISC_RST       = 8'h00;
  // Clock division ratio field encodings
  localparam logic [1:0]   CLKDIV_MAIN_D8 = 2'h0;
  localparam logic [1:0]   CLKDIV_MAIN_D2 = 2'h1;
  localparam logic [1:0]   CLKDIV_ROSC    = 2'h2;
  localparam logic [1:0]   CLKDIV_MAIN_D1 = 2'h3;
  // Internal oscillator divider settings
  localparam logic [1:0]   ROSC_DIV_MID   = 2'h2;
  localparam logic [1:0]   ROSC_DIV_RST   = 2'h2;
  // Automatic stabilization wait load values
  localparam logic [7:0]   AUTO_T1        = 8'h01;
  localparam logic [7:0]   AUTO_PRE       = 8'hFF;
  // Start address location in boot ROM
  localparam logic [15:0]  BOOT_VECTOR    = 16'hFFFC;
  localparam logic [15:0]  USER_VECTOR    = 16'hFFFC;

  typedef enum logic [1:0] {OCC_RUN, OCC_STOPPED, OCC_STABILIZE} occ_state_t;
endpackage : occ_pkg

// ===== design/occ_stab_timer.sv
`timescale 1ns/1ps
module occ_stab_timer
  import occ_pkg::*;
#(
  parameter int W = 8
) (
  input  wire logic         clock,     // System clock
  input  wire logic         rst,       // Async reset, high
  input  wire logic         load,      // Load both counters
  input  wire logic [W-1:0] load_t1,   // Timer value
  input  wire logic [W-1:0] load_pre,  // Prescaler value
  input  wire logic         tick,      // Count enable
  output logic              underflow  // One-cycle pulse
);
  logic [W-1:0] pre;
  logic [W-1:0] pre_reload;
  logic [W-1:0] t1;
  logic [W-1:0] next_pre;
  logic [W-1:0] next_pre_reload;
  logic [W-1:0] next_t1;
  logic         next_underflow;

  // Prescaler feeds timer; timer underflow at zero ends the wait
  always_comb begin
    next_pre        = pre;
    next_pre_reload = pre_reload;
    next_t1         = t1;
    next_underflow  = 1'b0;
    if (load) begin
      next_pre        = load_pre;
      next_pre_reload = load_pre;
      next_t1         = load_t1;
    end else if (tick) begin
      if (pre == '0) begin
        next_pre = pre_reload;
        if (t1 == '0) begin
          next_underflow = 1'b1;
          next_t1        = load_t1;
        end else begin
          next_t1 = t1 - 1'b1;
        end
      end else begin
        next_pre = pre - 1'b1;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pre        <= '0;
      pre_reload <= '0;
      t1         <= '0;
      underflow  <= 1'b0;
    end else begin
      pre        <= next_pre;
      pre_reload <= next_pre_reload;
      t1         <= next_t1;
      underflow  <= next_underflow;
    end
  end
endmodule : occ_stab_timer

// ===== dv/test_occ_clock_control.sv
`timescale 1ns/1ps
// Compare a design value with its expectation and count both outcomes
`define CHK(nm, exp, act) begin \
  checks_done++; \
  if ((act) !== (exp)) begin \
    n_mismatch++; \
    $display("mismatch %s expected %0h seen %0h", nm, exp, act); \
  end \
end

module test_occ_clock_control;
  import occ_pkg::*;

  logic        clock, rst, main_osc_tick, rosc_tick;
  logic        cpumode_wr, rosc_div_wr, misc_wr, t1_wr;
  logic [7:0]  cpumode_wdata, misc_wdata, t1_wdata, pre_wdata;
  logic [1:0]  rosc_div_wdata, rosc_div;
  logic        stop_instruction, stop_allowed, wake_event, osc_stop_det;
  logic        flash_busy, wdt_running, boot_select_pin;
  logic [7:0]  cpumode_rdata, misc_rdata;
  logic        main_osc_enable, rosc_enable, cpu_clk_en, wdt_count_en;
  logic        stop_active, osc_stop_reset, wdt_reinit, boot_mode;
  logic [15:0] reset_vector;
  int          n_mismatch, checks_done, cycles, n;
  logic        gated;

  occ_clock_control u_dut (
    .clock(clock), .rst(rst), .main_osc_tick(main_osc_tick),
    .rosc_tick(rosc_tick), .cpumode_wr(cpumode_wr),
    .cpumode_wdata(cpumode_wdata), .rosc_div_wr(rosc_div_wr),
    .rosc_div_wdata(rosc_div_wdata), .misc_wr(misc_wr),
    .misc_wdata(misc_wdata), .t1_wr(t1_wr), .t1_wdata(t1_wdata),
    .pre_wdata(pre_wdata), .stop_instruction(stop_instruction),
    .stop_allowed(stop_allowed), .wake_event(wake_event),
    .osc_stop_det(osc_stop_det), .flash_busy(flash_busy),
    .wdt_running(wdt_running), .boot_select_pin(boot_select_pin),
    .cpumode_rdata(cpumode_rdata), .misc_rdata(misc_rdata),
    .rosc_div(rosc_div), .main_osc_enable(main_osc_enable),
    .rosc_enable(rosc_enable), .cpu_clk_en(cpu_clk_en),
    .wdt_count_en(wdt_count_en), .stop_active(stop_active),
    .osc_stop_reset(osc_stop_reset), .wdt_reinit(wdt_reinit),
    .boot_mode(boot_mode), .reset_vector(reset_vector)
  );

  // 100 MHz clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // Verdict and end of run, shared by the main flow and the watchdog
  task automatic end_sim;
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_sim

  // Hang guard, well above the two stabilization waits
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      end_sim();
    end
  end

  // Let k edges pass, then sample settled outputs
  task automatic step(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask : step

  // One write strobe: 0 mode register, 1 misc, 2 divider select
  task automatic wr(input int sel, input logic [7:0] d);
    @(posedge clock);
    case (sel)
      0: begin cpumode_wr <= 1'b1; cpumode_wdata <= d; end
      1: begin misc_wr <= 1'b1; misc_wdata <= d; end
      default: begin rosc_div_wr <= 1'b1; rosc_div_wdata <= d[1:0]; end
    endcase
    @(posedge clock);
    cpumode_wr  <= 1'b0;
    misc_wr     <= 1'b0;
    rosc_div_wr <= 1'b0;
    #1;
  endtask : wr

  // Stop, wake, then count edges until the stabilization wait ends
  task automatic stop_run(output int k, output logic ok_gate);
    k = 0;
    ok_gate = 1'b1;
    @(posedge clock);
    stop_instruction <= 1'b1;
    @(posedge clock);
    stop_instruction <= 1'b0;
    step(3);
    `CHK("stop_active", 1'b1, stop_active)
    `CHK("main_en_stopped", 1'b0, main_osc_enable)
    @(posedge clock);
    wake_event    <= 1'b1;
    main_osc_tick <= 1'b1;
    @(posedge clock);
    wake_event <= 1'b0;
    while (k < 2000) begin
      step(1);
      if (stop_active !== 1'b1) break;
      if (cpu_clk_en !== 1'b0) ok_gate = 1'b0;
      k++;
    end
    @(posedge clock);
    main_osc_tick <= 1'b0;
    #1;
  endtask : stop_run

  // Keep both sources ticking for k edges, count processor clock pulses
  task automatic count_clk(input int k, output int c);
    c = 0;
    @(posedge clock);
    main_osc_tick <= 1'b1;
    rosc_tick     <= 1'b1;
    repeat (k) begin
      step(1);
      if (cpu_clk_en === 1'b1) c++;
    end
    @(posedge clock);
    main_osc_tick <= 1'b0;
    rosc_tick     <= 1'b0;
    #1;
  endtask : count_clk

  initial begin
    n_mismatch = 0; checks_done = 0; cycles = 0;
    rst = 1'b1; main_osc_tick = 1'b0; rosc_tick = 1'b0;
    cpumode_wr = 1'b0; cpumode_wdata = 8'h00; rosc_div_wr = 1'b0;
    rosc_div_wdata = 2'h0; misc_wr = 1'b0; misc_wdata = 8'h00;
    t1_wr = 1'b0; t1_wdata = 8'h00; pre_wdata = 8'h00;
    stop_instruction = 1'b0; stop_allowed = 1'b1; wake_event = 1'b0;
    osc_stop_det = 1'b0; flash_busy = 1'b0; wdt_running = 1'b0;
    boot_select_pin = 1'b0;
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    step(2);
    // Reset state and normal start
    `CHK("cpumode_rst", CPUMODE_RST, cpumode_rdata)
    `CHK("misc_rst", MISC_RST, misc_rdata)
    `CHK("boot_mode_low", 1'b0, boot_mode)
    `CHK("vector", USER_VECTOR, reset_vector)
    // Main to internal switch forces the middle-speed divider
    wr(2, 8'h00);
    `CHK("rosc_div_wr", 2'h0, rosc_div)
    wr(0, 8'h80);
    `CHK("cpumode_int", 8'h80, cpumode_rdata)
    `CHK("rosc_div_mid", ROSC_DIV_MID, rosc_div)
    // Locked bits ignore the second write
    wr(0, 8'hA3);
    `CHK("cpumode_lock", 8'h80, cpumode_rdata)
    // Internal source: 8 then 16 ticks per processor clock
    count_clk(16, n);
    `CHK("clk_rosc_d8", 2, n)
    wr(2, 8'h03);
    count_clk(32, n);
    `CHK("clk_rosc_d16", 2, n)
    // Watchdog follows the internal oscillator only while it is the selected source
    @(posedge clock); rosc_tick <= 1'b1;
    @(posedge clock); rosc_tick <= 1'b0;
    #1;
    `CHK("wdt_rosc", 1'b1, wdt_count_en)
    @(posedge clock); main_osc_tick <= 1'b1;
    @(posedge clock); main_osc_tick <= 1'b0;
    #1;
    `CHK("wdt_no_main", 1'b0, wdt_count_en)
    // Main oscillator may stop while internal clock runs the core
    wr(0, 8'h90);
    `CHK("main_off", 1'b0, main_osc_enable)
    `CHK("rosc_on", 1'b1, rosc_enable)
    wr(0, 8'hC0);
    step(2);
    `CHK("main_on", 1'b1, main_osc_enable)
    @(posedge clock); main_osc_tick <= 1'b1;
    @(posedge clock); main_osc_tick <= 1'b0;
    #1;
    `CHK("wdt_main", 1'b1, wdt_count_en)
    // Refused stop while the stop function is off
    @(posedge clock); stop_allowed <= 1'b0; stop_instruction <= 1'b1;
    @(posedge clock); stop_instruction <= 1'b0; stop_allowed <= 1'b1;
    step(2);
    `CHK("stop_refused", 1'b0, stop_active)
    // Automatic wait: 512 ticks of the main source
    stop_run(n, gated);
    `CHK("auto_wait", 1'b1, (n >= 510 && n <= 518))
    `CHK("clk_gated", 1'b1, gated)
    `CHK("clk_resume", 1'b1, cpu_clk_en)
    // Software-loaded wait: (1+1)*(3+1) = 8 ticks
    wr(1, 8'h01);
    // Timer reloaded after the first stop overwrote it
    @(posedge clock);
    t1_wr     <= 1'b1;
    t1_wdata  <= 8'h03;
    pre_wdata <= 8'h01;
    @(posedge clock); t1_wr <= 1'b0;
    stop_run(n, gated);
    `CHK("soft_wait", 1'b1, (n >= 6 && n <= 14))
    `CHK("soft_resume", 1'b1, cpu_clk_en)
    // Detection disabled: no reaction
    wr(1, 8'h00);
    @(posedge clock); osc_stop_det <= 1'b1;
    @(posedge clock); osc_stop_det <= 1'b0;
    step(2);
    `CHK("det_off", 8'h00, misc_rdata)
    // Detection reset keeps enable and status, clears the rest
    wr(1, 8'h03);
    @(posedge clock); osc_stop_det <= 1'b1;
    @(posedge clock); osc_stop_det <= 1'b0;
    #1;
    `CHK("osc_reset", 1'b1, osc_stop_reset)
    step(3);
    `CHK("misc_kept", 8'h0A, misc_rdata)
    `CHK("cpumode_reinit", CPUMODE_RST, cpumode_rdata)
    wr(1, 8'h02);
    `CHK("stat_kept", 8'h0A, misc_rdata)
    wr(1, 8'h00);
    `CHK("stat_clr", 8'h00, misc_rdata)
    // Core source cannot be stopped; main/2 then main/8
    wr(0, 8'h58);
    `CHK("main_kept", 8'h48, cpumode_rdata)
    `CHK("rosc_off", 1'b0, rosc_enable)
    count_clk(16, n);
    `CHK("clk_main_d2", 8, n)
    wr(0, 8'h18);
    `CHK("main_d8", 8'h08, cpumode_rdata)
    count_clk(16, n);
    `CHK("clk_main_d8", 2, n)
    // Watchdog cleared only while running during a flash operation
    @(posedge clock); flash_busy <= 1'b1;
    step(2);
    `CHK("reinit_idle", 1'b0, wdt_reinit)
    @(posedge clock); wdt_running <= 1'b1;
    step(2);
    `CHK("reinit_on", 1'b1, wdt_reinit)
    @(posedge clock); flash_busy <= 1'b0;
    step(2);
    `CHK("reinit_off", 1'b0, wdt_reinit)
    // External reset mid-run with the boot strap high
    wr(1, 8'h02);
    @(posedge clock); osc_stop_det <= 1'b1; boot_select_pin <= 1'b1;
    @(posedge clock); osc_stop_det <= 1'b0; rst <= 1'b1;
    step(3);
    @(posedge clock); rst <= 1'b0;
    step(2);
    `CHK("boot_mode_high", 1'b1, boot_mode)
    `CHK("boot_vector", BOOT_VECTOR, reset_vector)
    `CHK("ext_rst_clr", 8'h00, misc_rdata)
    end_sim();
  end
endmodule : test_occ_clock_control
